//--- rtl/sgp_in_latch.sv
// clocked input latch for both ports
`timescale 1ns/10ps
`default_nettype none

module sgp_in_latch
(
  input  wire logic clk,
  input  wire logic rst_b,
  sgp_latch_if.latch lif
);
  import sgp_pkg::*;

  typedef struct packed {
    sgp_pins_s held;
  } sgp_latch_s;

  sgp_latch_s st;
  sgp_latch_s next_st;

  // ========================================================================
  // sample every rising clock edge
  always_comb
  begin
    next_st      = st;
    next_st.held = lif.raw;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lif.held = st.held;

endmodule : sgp_in_latch

`default_nettype wire

//--- rtl/sgp_latch_if.sv
// interface between the port block and its input latch
`timescale 1ns/10ps
`default_nettype none

interface sgp_latch_if;
  import sgp_pkg::*;

  sgp_pins_s raw;
  sgp_pins_s held;

  modport core
  (
    output raw,
    input  held
  );

  modport latch
  (
    input  raw,
    output held
  );

endinterface : sgp_latch_if

`default_nettype wire

//--- rtl/sgp_params.svh
// constants for the segment and input port block
`ifndef SGP_PARAMS_SVH
`define SGP_PARAMS_SVH

// ==========================================================================
// register offsets
`define SGP_P4_DATA_OFS     16'hFFC8
`define SGP_P4_DIR_OFS      16'hFFCA
`define SGP_P4_OD_OFS       16'hF1CA
`define SGP_P5_DATA_OFS     16'hFF80
`define SGP_CFG_HIGH_OFS    16'hFF82

// ==========================================================================
// reset values
`define SGP_P4_DATA_RST     8'h00
`define SGP_P4_DIR_RST      8'h00
`define SGP_P4_OD_RST       2'h0
`define SGP_CFG_HIGH_RST    8'h00
`define SGP_SEG_ADDR_RST    8'h00
`define SGP_RDATA_RST       16'h0000

// ==========================================================================
// field positions
`define SGP_OD_LO_BIT       6
`define SGP_OD_HI_BIT       7
`define SGP_CFG_HIGH_LO     8
`define SGP_CFG_HIGH_HI     15
`define SGP_SEGSEL_LO       3
`define SGP_SEGSEL_HI       4

// ==========================================================================
// line assignments of the upper port lines
`define SGP_LINE_RX2        4
`define SGP_LINE_RX1        5
`define SGP_LINE_TX1        6
`define SGP_LINE_TX2        7

// ==========================================================================
// segment line masks per select code
`define SGP_MASK_NONE       8'h00
`define SGP_MASK_TWO        8'h03
`define SGP_MASK_FOUR       8'h0F
`define SGP_MASK_EIGHT      8'hFF

`endif

//--- rtl/sgp_pkg.sv
// types shared by the segment and input port block
package sgp_pkg;

  // ========================================================================
  // segment line select codes
  typedef enum logic [1:0] {
    SGP_SEG_NONE  = 2'b01,
    SGP_SEG_TWO   = 2'b11,
    SGP_SEG_FOUR  = 2'b00,
    SGP_SEG_EIGHT = 2'b10
  } sgp_seg_e;

  typedef logic [7:0]  sgp_byte_t;
  typedef logic [15:0] sgp_word_t;

  // ========================================================================
  // sampled pin levels
  typedef struct packed {
    sgp_byte_t p4;
    sgp_word_t p5;
  } sgp_pins_s;

endpackage : sgp_pkg

//--- rtl/sgp_top.sv
// segment-capable 8-bit port and 16-bit input-only port
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sgp_params.svh"

module sgp_top
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  // register port
  input  wire logic [15:0]      reg_addr,
  input  wire sgp_pkg::sgp_word_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata,
  // 8-bit port pins
  input  wire sgp_pkg::sgp_byte_t port4_pin_in,
  output logic [7:0]            port4_pin_out,
  output logic [7:0]            port4_pin_oe_b,
  // configuration bus sampled at reset release
  input  wire logic [15:0]      reset_config_bus_pins,
  // external bus segment address
  input  wire logic             ext_seg_cycle,
  input  wire logic [7:0]       ext_seg_addr,
  // serial bus controllers
  input  wire logic             first_bus_ctrl_en,
  input  wire logic             second_bus_ctrl_en,
  input  wire logic             first_bus_ctrl_transmit,
  input  wire logic             second_bus_ctrl_transmit,
  output logic                  first_bus_ctrl_receive,
  output logic                  second_bus_ctrl_receive,
  // input-only port
  input  wire sgp_pkg::sgp_word_t input_only_port_pins,
  output logic [15:0]           analog_channel_inputs,
  output logic                  timer_six_dir_input,
  output logic                  timer_five_dir_input,
  output logic                  timer_six_count_input,
  output logic                  timer_five_count_input,
  output logic                  timer_four_dir_input,
  output logic                  timer_two_dir_input,
  output logic [1:0]            segment_line_select
);
  import sgp_pkg::*;

  // ========================================================================
  // state
  typedef struct packed {
    sgp_byte_t data;
    sgp_byte_t dir;
    logic [1:0] od;
    sgp_byte_t cfg_high;
    logic      cfg_pending;
    sgp_byte_t seg_addr;
    sgp_word_t rdata;
    sgp_byte_t pin_out;
    sgp_byte_t pin_oe_b;
  } sgp_state_s;

  sgp_state_s st;
  sgp_state_s next_st;

  sgp_latch_if lif ();

  // ========================================================================
  // input latch
  assign lif.raw = '{p4: port4_pin_in, p5: input_only_port_pins};

  sgp_in_latch u_latch
  (
    .clk   (clk),
    .rst_b (rst_b),
    .lif   (lif)
  );

  // ========================================================================
  // helpers
  function automatic sgp_byte_t seg_mask(input logic [1:0] sel);
    sgp_seg_e code;
    code = sgp_seg_e'(sel);
    unique case (code)
      SGP_SEG_NONE:  seg_mask = `SGP_MASK_NONE;
      SGP_SEG_TWO:   seg_mask = `SGP_MASK_TWO;
      SGP_SEG_FOUR:  seg_mask = `SGP_MASK_FOUR;
      SGP_SEG_EIGHT: seg_mask = `SGP_MASK_EIGHT;
    endcase
  endfunction : seg_mask

  function automatic sgp_byte_t od_full(input logic [1:0] od);
    od_full = {od, 6'h00};
  endfunction : od_full

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  // ========================================================================
  // address decode shared by writes and reads
  logic sel_data;
  logic sel_dir;
  logic sel_od;
  logic sel_in;
  logic sel_cfg;

  always_comb
  begin
    sel_data = hit(reg_addr, `SGP_P4_DATA_OFS);
    sel_dir  = hit(reg_addr, `SGP_P4_DIR_OFS);
    sel_od   = hit(reg_addr, `SGP_P4_OD_OFS);
    sel_in   = hit(reg_addr, `SGP_P5_DATA_OFS);
    sel_cfg  = hit(reg_addr, `SGP_CFG_HIGH_OFS);
  end

  // ========================================================================
  // line roles
  typedef enum logic [1:0] {
    SGP_ROLE_GPIO = 2'b00,
    SGP_ROLE_SEG  = 2'b01,
    SGP_ROLE_TX   = 2'b10
  } sgp_role_e;

  // ========================================================================
  // pin drive and registers
  logic [1:0] cur_sel;
  sgp_byte_t  mask;
  sgp_byte_t  od8;
  sgp_byte_t  tx_use;
  sgp_byte_t  tx_val;
  sgp_byte_t  val;
  sgp_byte_t  drive;
  sgp_byte_t  od_act;
  sgp_role_e  role [8];

  // until the strap capture the select holds its reset code, which
  // already routes four segment lines, lines 0 to 3, so fetches on up to four lines work at once
  assign cur_sel = st.cfg_high[`SGP_SEGSEL_HI:`SGP_SEGSEL_LO];
  assign mask    = seg_mask(cur_sel);
  assign od8     = od_full(st.od);

  // controllers only where no segment line sits; eight segment lines
  // with controllers enabled is a system error and segment wins
  always_comb
  begin
    tx_use = 8'h00;
    tx_val = 8'h00;
    if (first_bus_ctrl_en && !mask[`SGP_LINE_TX1])
    begin
      tx_use[`SGP_LINE_TX1] = 1'b1;
      tx_val[`SGP_LINE_TX1] = first_bus_ctrl_transmit;
    end
    if (second_bus_ctrl_en && !mask[`SGP_LINE_TX2])
    begin
      tx_use[`SGP_LINE_TX2] = 1'b1;
      tx_val[`SGP_LINE_TX2] = second_bus_ctrl_transmit;
    end
  end

  // segment beats controller beats plain port use
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (mask[i])
      begin
        role[i] = SGP_ROLE_SEG;
      end
      else if (tx_use[i])
      begin
        role[i] = SGP_ROLE_TX;
      end
      else
      begin
        role[i] = SGP_ROLE_GPIO;
      end
    end
  end

  always_comb
  begin
    val    = 8'h00;
    drive  = 8'h00;
    od_act = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      unique case (role[i])
        SGP_ROLE_SEG:
        begin
          val[i]   = st.seg_addr[i];
          drive[i] = 1'b1;
        end
        SGP_ROLE_TX:
        begin
          val[i]   = tx_val[i];
          drive[i] = 1'b1;
        end
        SGP_ROLE_GPIO:
        begin
          val[i]   = st.data[i];
          drive[i] = st.dir[i];
        end
      endcase
      od_act[i] = od8[i] & ~mask[i];
    end
  end

  always_comb
  begin
    next_st       = st;
    next_st.rdata = `SGP_RDATA_RST;

    // strap capture on the first edge after reset release
    if (st.cfg_pending)
    begin
      next_st.cfg_high =
        reset_config_bus_pins[`SGP_CFG_HIGH_HI:`SGP_CFG_HIGH_LO];
      next_st.cfg_pending = 1'b0;
    end

    // segment address follows the external bus during segmented cycles
    if (ext_seg_cycle)
    begin
      next_st.seg_addr = ext_seg_addr;
    end

    // register writes
    if (reg_wr)
    begin
      if (sel_data)
      begin
        next_st.data = reg_wdata[7:0];
      end
      else if (sel_dir)
      begin
        next_st.dir = reg_wdata[7:0];
      end
      else if (sel_od)
      begin
        next_st.od = reg_wdata[`SGP_OD_HI_BIT:`SGP_OD_LO_BIT];
      end
      else
      begin
        // input-only port and config register ignore writes
        next_st.od = st.od;
      end
    end

    // register reads, data stand one cycle only
    if (reg_rd)
    begin
      if (sel_data)
      begin
        next_st.rdata = {8'h00, lif.held.p4};
      end
      else if (sel_dir)
      begin
        next_st.rdata = {8'h00, st.dir};
      end
      else if (sel_od)
      begin
        next_st.rdata = {8'h00, od8};
      end
      else if (sel_in)
      begin
        next_st.rdata = lif.held.p5;
      end
      else if (sel_cfg)
      begin
        next_st.rdata = {8'h00, st.cfg_high};
      end
      else
      begin
        next_st.rdata = `SGP_RDATA_RST;
      end
    end

    // pins from flops; open drain releases instead of driving high
    next_st.pin_out  = val;
    next_st.pin_oe_b = ~(drive & ~(od_act & val));
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st.data        <= `SGP_P4_DATA_RST;
      st.dir         <= `SGP_P4_DIR_RST;
      st.od          <= `SGP_P4_OD_RST;
      st.cfg_high    <= `SGP_CFG_HIGH_RST;
      st.cfg_pending <= 1'b1;
      st.seg_addr    <= `SGP_SEG_ADDR_RST;
      st.rdata       <= `SGP_RDATA_RST;
      st.pin_out     <= 8'h00;
      st.pin_oe_b    <= 8'hFF;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs
  assign reg_rdata      = st.rdata;
  assign port4_pin_out  = st.pin_out;
  assign port4_pin_oe_b = st.pin_oe_b;
  assign segment_line_select = cur_sel;

  // receive paths read the input latch, always available
  assign first_bus_ctrl_receive  = lif.held.p4[`SGP_LINE_RX1];
  assign second_bus_ctrl_receive = lif.held.p4[`SGP_LINE_RX2];

  // analog channels bypass the latch: no sampling delay on the signal
  assign analog_channel_inputs = input_only_port_pins;

  assign timer_six_dir_input    = lif.held.p5[10];
  assign timer_five_dir_input   = lif.held.p5[11];
  assign timer_six_count_input  = lif.held.p5[12];
  assign timer_five_count_input = lif.held.p5[13];
  assign timer_four_dir_input   = lif.held.p5[14];
  assign timer_two_dir_input    = lif.held.p5[15];

endmodule : sgp_top

`default_nettype wire

//--- tb/sgp_chk_sva.sv
// assertion checker for the segment and input port block
`timescale 1ns/10ps
`default_nettype none
`include "sgp_params.svh"
module sgp_chk
  import sgp_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [15:0]        reg_addr,
  input wire sgp_pkg::sgp_word_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  input wire sgp_pkg::sgp_byte_t port4_pin_in,
  input wire logic [7:0]         port4_pin_oe_b,
  input wire sgp_pkg::sgp_word_t input_only_port_pins,
  input wire logic [15:0]        analog_channel_inputs,
  input wire logic               timer_six_dir_input,
  input wire logic               timer_five_dir_input,
  input wire logic               timer_six_count_input,
  input wire logic               timer_five_count_input,
  input wire logic               timer_four_dir_input,
  input wire logic               timer_two_dir_input,
  input wire logic               first_bus_ctrl_receive,
  input wire logic               second_bus_ctrl_receive,
  input wire logic [1:0]         segment_line_select
);
  // ========
  // lines owned by segment address
  logic [7:0] seg_m;
  always_comb
  begin
    case (segment_line_select)
      SGP_SEG_NONE: seg_m = `SGP_MASK_NONE;
      SGP_SEG_TWO:  seg_m = `SGP_MASK_TWO;
      SGP_SEG_FOUR: seg_m = `SGP_MASK_FOUR;
      default:      seg_m = `SGP_MASK_EIGHT;
    endcase
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence dir_wr_s;
    reg_wr && reg_addr == `SGP_P4_DIR_OFS;
  endsequence
  sequence dir_quiet_s;
    !(reg_wr && reg_addr == `SGP_P4_DIR_OFS) [*3];
  endsequence
  // ========
  // properties
  rd_idle_a: assert property (
    !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
  od_bits_a: assert property (
    reg_rd && reg_addr == `SGP_P4_OD_OFS
    |=> (reg_rdata & 16'hFF3F) == 16'h0000)
    else $error("open drain spare bits set");
  analog_pass_a: assert property (
    analog_channel_inputs == input_only_port_pins) else $error("analog path");
  timer_map_a: assert property (
    $past(rst_b) |-> {timer_two_dir_input, timer_four_dir_input,
    timer_five_count_input, timer_six_count_input, timer_five_dir_input,
    timer_six_dir_input} == $past(input_only_port_pins[15:10]))
    else $error("timer inputs wrong");
  sel_hold_a: assert property (
    $past(rst_b) && $past(rst_b, 2) |-> $stable(segment_line_select))
    else $error("select moved");
  seg_drive_a: assert property (
    $past(rst_b) && $past(rst_b, 2)
    |-> (port4_pin_oe_b & $past(seg_m)) == 8'h00)
    else $error("segment line not driven");
  rx_map_a: assert property (
    $past(rst_b) |-> {first_bus_ctrl_receive, second_bus_ctrl_receive}
    == $past(port4_pin_in[5:4])) else $error("receive lines wrong");
  dir_drive_a: assert property (
    dir_wr_s ##1 dir_quiet_s |-> seg_m[2]
    || port4_pin_oe_b[2] == !$past(reg_wdata[2], 3))
    else $error("line two direction wrong");
endmodule : sgp_chk

bind sgp_top sgp_chk chk_u
(
  .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .port4_pin_in, .port4_pin_oe_b, .input_only_port_pins,
  .analog_channel_inputs, .timer_six_dir_input, .timer_five_dir_input,
  .timer_six_count_input, .timer_five_count_input, .timer_four_dir_input,
  .timer_two_dir_input, .first_bus_ctrl_receive, .second_bus_ctrl_receive,
  .segment_line_select
);
`default_nettype wire

//--- tb/sgp_far_model.sv
// far side of the port lines: pull-ups and remote drivers
`timescale 1ns/10ps
`default_nettype none
module sgp_far_model
(
  input  wire logic [7:0] port4_pin_out,
  input  wire logic [7:0] port4_pin_oe_b,
  input  wire logic [7:0] far_drv,
  input  wire logic [7:0] far_drv_en,
  output logic      [7:0] port4_pin_in
);
  // wired-and: a released line shows the far driver or the pull-up
  always_comb
    for (int i = 0; i < 8; i++)
      port4_pin_in[i] = (port4_pin_oe_b[i] | port4_pin_out[i])
        & (!far_drv_en[i] | far_drv[i]);
endmodule : sgp_far_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the segment and input port block
`timescale 1ns/10ps
`default_nettype none
`include "sgp_params.svh"
module tb;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        ext_seg_cycle = 1'b0, first_bus_ctrl_en = 1'b0;
  logic        second_bus_ctrl_en = 1'b0, first_bus_ctrl_transmit = 1'b0;
  logic        second_bus_ctrl_transmit = 1'b0, rx1, rx2;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic [15:0] reset_config_bus_pins = 16'h0000, analog_channel_inputs;
  logic [15:0] input_only_port_pins = 16'h0000;
  logic [7:0]  ext_seg_addr = 8'h00, far_drv = 8'h00, far_drv_en = 8'h00;
  logic [7:0]  port4_pin_in, port4_pin_out, port4_pin_oe_b;
  logic [5:0]  tmr;
  logic [1:0]  segment_line_select;
  int          n_fail = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;

  sgp_top dut_u
  (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port4_pin_in, .port4_pin_out, .port4_pin_oe_b, .reset_config_bus_pins,
    .ext_seg_cycle, .ext_seg_addr, .first_bus_ctrl_en, .second_bus_ctrl_en,
    .first_bus_ctrl_transmit, .second_bus_ctrl_transmit,
    .first_bus_ctrl_receive(rx1), .second_bus_ctrl_receive(rx2),
    .input_only_port_pins, .analog_channel_inputs, .segment_line_select,
    .timer_six_dir_input(tmr[0]), .timer_five_dir_input(tmr[1]),
    .timer_six_count_input(tmr[2]), .timer_five_count_input(tmr[3]),
    .timer_four_dir_input(tmr[4]), .timer_two_dir_input(tmr[5])
  );
  sgp_far_model far_u
  (
    .port4_pin_out, .port4_pin_oe_b, .far_drv, .far_drv_en, .port4_pin_in
  );

  // ========
  // shared tasks
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [15:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rc

  task automatic do_reset(input logic [1:0] code);
    @(posedge clk);
    rst_b <= 1'b0;
    reset_config_bus_pins <= {3'h0, code, 11'h000};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // ========
  // scenarios
  task automatic s_codes;
    logic [1:0] c [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    logic [7:0] m [4] = '{8'h00, 8'h03, 8'h0F, 8'hFF};
    // controllers stay off here, eight lines included
    for (int i = 0; i < 4; i++)
    begin
      do_reset(c[i]);
      #1 chk("select", 16'(c[i]), 16'(segment_line_select));
      chk("oe_b", {8'h00, ~m[i]}, 16'(port4_pin_oe_b));
      rc(`SGP_P4_DIR_OFS, 16'h0000);
      rc(`SGP_P4_OD_OFS, 16'h0000);
      wr(`SGP_CFG_HIGH_OFS, 16'hFFFF);
      rc(`SGP_CFG_HIGH_OFS, 16'({c[i], 3'h0}));
    end
  endtask : s_codes

  task automatic s_gpio;
    wr(`SGP_P4_DIR_OFS, 16'hFFFF);
    wr(`SGP_P4_DATA_OFS, 16'hFF5A);
    rc(`SGP_P4_DIR_OFS, 16'h00FF);
    repeat (2) @(posedge clk);
    #1 chk("oe_b", 16'h0000, 16'(port4_pin_oe_b));
    chk("out", 16'h0058, 16'(port4_pin_out & 8'hFC));
    rc(`SGP_P4_DATA_OFS, 16'h0058);
    wr(`SGP_P4_OD_OFS, 16'hFFFF);
    rc(`SGP_P4_OD_OFS, 16'h00C0);
    @(posedge clk);
    far_drv_en <= 8'h40;
    repeat (2) @(posedge clk);
    #1 chk("oe_b", 16'h0040, 16'(port4_pin_oe_b));
    rc(`SGP_P4_DATA_OFS, 16'h0018);
    wr(`SGP_P4_DIR_OFS, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk("oe_b", 16'h00FC, 16'(port4_pin_oe_b));
  endtask : s_gpio

  task automatic s_seg;
    @(posedge clk);
    ext_seg_cycle <= 1'b1;
    ext_seg_addr <= 8'hA6;
    repeat (3) @(posedge clk);
    ext_seg_cycle <= 1'b0;
    ext_seg_addr <= 8'h55;
    repeat (3) @(posedge clk);
    #1 chk("seg", 16'h0002, 16'(port4_pin_out & 8'h03));
  endtask : s_seg

  task automatic s_ctrl;
    logic [3:0] txv;
    wr(`SGP_P4_OD_OFS, 16'h0000);
    @(posedge clk);
    // only two segment lines while controllers run
    first_bus_ctrl_en <= 1'b1;
    second_bus_ctrl_en <= 1'b1;
    second_bus_ctrl_transmit <= 1'b1;
    far_drv_en <= 8'h30;
    far_drv <= 8'h20;
    repeat (3) @(posedge clk);
    #1 txv = {port4_pin_oe_b[7:6], port4_pin_out[7:6]};
    chk("tx", 16'h0002, 16'(txv));
    chk("rx", 16'h0002, 16'({rx1, rx2}));
  endtask : s_ctrl

  task automatic s_inport;
    @(posedge clk);
    input_only_port_pins <= 16'hA5C3;
    #1 chk("analog", 16'hA5C3, analog_channel_inputs);
    @(posedge clk);
    #1 chk("timer", 16'h0029, 16'(tmr));
    rc(`SGP_P5_DATA_OFS, 16'hA5C3);
    wr(`SGP_P5_DATA_OFS, 16'hFFFF);
    rc(`SGP_P5_DATA_OFS, 16'hA5C3);
    rc(`SGP_P4_DIR_OFS, 16'h0000);
    rc(16'h1234, 16'h0000);
  endtask : s_inport

  initial
  begin
    s_codes();
    do_reset(2'h3);
    s_gpio();
    s_seg();
    s_ctrl();
    s_inport();
    conclude();
  end

  // hang guard
  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule : tb
`default_nettype wire
